/* File: hdl/ofm_pkg.sv */
// constants for the display page and font address mapper
// assumes 8 Kbyte display ram and a 1024-glyph font rom
package ofm_pkg;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_NATIONAL_CHARSET_REG = 8'hf5;
  localparam logic [7:0] IDX_DPTR = 8'hf0;
  localparam logic [7:0] IDX_DCTL = 8'hf1;
  localparam logic [7:0] IDX_STAT = 8'hf2;

  // ==========================================================
  // register fields and reset values
  localparam int NATIONAL_CHARSET_REG_SET_BIT  = 7;
  localparam int NATIONAL_CHARSET_REG_MAP_BIT  = 6;
  localparam int DCTL_SCR_BIT  = 2;
  localparam int STAT_ERR_BIT  = 0;
  localparam logic [7:0] NATIONAL_CHARSET_REG_RST = 8'h00;
  localparam logic [7:0] DPTR_RST = 8'h00;
  localparam logic [2:0] DCTL_RST = 3'h0;

  // ==========================================================
  // display ram layout
  localparam int          RAM_AW       = 13;
  localparam int          HALF_SHIFT   = 9;
  localparam logic [12:0] HALF_BLK     = 13'h0200;
  localparam logic [12:0] FULL_BLK     = 13'h0400;
  localparam logic [6:0]  ROW_LEN      = 7'h28;
  localparam logic [12:0] HS_ATTR_OFS  = 13'h0080;
  localparam logic [12:0] ROW_ATTR_OFS = 13'h0100;
  localparam logic [4:0]  ROW_ATTR_NUM = 5'h0c;
  localparam logic [4:0]  LINE_SCR_ROW = 5'h0c;
  localparam logic [4:0]  FULL_SCR_ROW = 5'h18;
  localparam logic [4:0]  FULL_LAST    = 5'h17;
  localparam logic [4:0]  HDR_ROWS     = 5'h03;

  // ==========================================================
  // font rom layout
  localparam logic [8:0] G0_1_BASE   = 9'h100;
  localparam logic [8:0] G0_2_BASE   = 9'h160;
  localparam logic [8:0] NAT_BASE    = 9'h100;
  localparam logic [8:0] NAT_LEN     = 9'h00d;
  localparam logic [8:0] EXT_HI_BASE = 9'h1c0;
  localparam logic [7:0] CODE_G0_LO  = 8'h20;
  localparam logic [7:0] CODE_G0_HI  = 8'h7f;
  localparam logic [7:0] CODE_EXT_A  = 8'ha0;
  localparam logic [7:0] CODE_EXT_E  = 8'he0;

  typedef enum logic [1:0] {
    MODE_PAR40_LINE = 2'b00,
    MODE_SER80_FULL = 2'b01,
    MODE_SER80_LINE = 2'b11
  } ofm_mode_t;

  typedef enum logic [2:0] {
    KIND_PAGE_CHAR = 3'h0,
    KIND_PAGE_ATTR = 3'h1,
    KIND_HDR_CHAR  = 3'h2,
    KIND_HDR_ATTR  = 3'h3,
    KIND_ROW_ATTR  = 3'h4,
    KIND_SCROLL    = 3'h5
  } ofm_kind_t;

endpackage

/* File: hdl/ofm_mapper.sv */
// display ram fetch address and font rom address generator
// assumes an apb master on core_clk and same-clock request logic
`timescale 1ns/100ps
// How it works
// - parallel line mode: char block at page pointer, attributes next
// - header and status rows come from the header block pointer
// - parallel header and status attributes sit at 80h in that block
// - line modes: twelve row attribute bytes at 100h in that block
// - line modes with scrolling: row 12 is the scroll buffer
// - serial 80 full page: left 1K block then right 1K block
// - full page scrolling: the 40 bytes after row 23
// - serial 80 line mode: left half block then right half block
// - two 512-glyph sets, set switch bit picks one
// - mosaics made in logic, serial attribute or shape bits pick
// - extended menu only in parallel mode via set select bit
// - map mode bit in charset register picks single or triple
// - single mode: 83 basic glyphs plus 13 from a subset
// - triple mode: three 96-glyph sets via a 2-bit subfield
// - serial mode decodes 8-bit codes
// - parallel mode decodes 9-bit codes
// - triple mode rom bases 020h, 100h, 160h; menu and extended
// - subset glyphs replace exactly thirteen code positions

module ofm_mapper #(
  parameter int ADDR_W = 12
) (
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 fetch_req,
  input  wire logic [2:0]           fetch_kind,
  input  wire logic [4:0]           fetch_row,
  input  wire logic [6:0]           fetch_col,
  output logic      [12:0]          ram_addr,
  output logic                      ram_valid,
  output logic                      fetch_err,
  input  wire logic                 font_req,
  input  wire logic [8:0]           char_code,
  input  wire logic                 serial_mosaic,
  input  wire logic                 serial_separated,
  input  wire logic [1:0]           shape_attr,
  input  wire logic                 g0_alt,
  output logic      [9:0]           rom_addr,
  output logic                      rom_valid,
  output logic                      glyph_mosaic,
  output logic                      glyph_separated
);

  // ==========================================================
  // elaboration check
  if (ADDR_W < 11) begin : g_chk
    $error("ofm_mapper: ADDR_W must be at least 11");
  end

  typedef struct packed {
    logic [7:0]  national_charset_reg;
    logic [3:0]  pg;
    logic [3:0]  hs;
    logic [1:0]  mode;
    logic        scr;
    logic        err_stk;
    logic [12:0] ram_addr;
    logic        ram_valid;
    logic        fetch_err;
    logic [9:0]  rom_addr;
    logic        rom_valid;
    logic        mosaic;
    logic        sep;
    logic [31:0] prdata;
  } ofm_state_t;

  typedef struct packed {
    logic [12:0] addr;
    logic        err;
  } ofm_fetch_t;

  typedef struct packed {
    logic [8:0] addr;
    logic       valid;
    logic       mosaic;
    logic       sep;
  } ofm_font_t;

  ofm_state_t s;
  ofm_state_t next_s;
  logic [7:0] idx;
  logic       hit;
  logic       par;
  logic       glyph_src_mosaic;

  // ==========================================================
  // apb decode
  assign idx = paddr[9:2];
  assign hit = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0) &&
               (idx == ofm_pkg::IDX_NATIONAL_CHARSET_REG || idx == ofm_pkg::IDX_DPTR ||
                idx == ofm_pkg::IDX_DCTL || idx == ofm_pkg::IDX_STAT);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign par     = (s.mode == ofm_pkg::MODE_PAR40_LINE);
  assign glyph_src_mosaic = par ? shape_attr[0] : serial_mosaic;

  // ==========================================================
  // national subset slot of a basic code
  function automatic logic [4:0] nat_slot(input logic [7:0] c);
    nat_slot = 5'h10;
    unique case (c)
      8'h23:   nat_slot = 5'h00;
      8'h24:   nat_slot = 5'h01;
      8'h40:   nat_slot = 5'h02;
      8'h5b:   nat_slot = 5'h03;
      8'h5c:   nat_slot = 5'h04;
      8'h5d:   nat_slot = 5'h05;
      8'h5e:   nat_slot = 5'h06;
      8'h5f:   nat_slot = 5'h07;
      8'h60:   nat_slot = 5'h08;
      8'h7b:   nat_slot = 5'h09;
      8'h7c:   nat_slot = 5'h0a;
      8'h7d:   nat_slot = 5'h0b;
      8'h7e:   nat_slot = 5'h0c;
      default: nat_slot = 5'h10;
    endcase
  endfunction

  // ==========================================================
  // display ram fetch address
  function automatic ofm_fetch_t do_fetch(
    input logic [2:0] kind,
    input logic [4:0] row,
    input logic [6:0] col,
    input logic [1:0] mode,
    input logic       scr,
    input logic [3:0] pg,
    input logic [3:0] hs
  );
    logic [12:0] pb;
    logic [12:0] hb;
    logic [4:0]  r;
    logic [6:0]  c;
    logic [12:0] ro;
    logic        rt;
    logic        full;
    ofm_fetch_t  f;
    pb   = {pg, 9'h000};
    hb   = {hs, 9'h000};
    full = (mode == ofm_pkg::MODE_SER80_FULL);
    rt   = (col >= ofm_pkg::ROW_LEN);
    c    = rt ? col - ofm_pkg::ROW_LEN : col;
    r    = (kind == 3'(ofm_pkg::KIND_SCROLL)) ?
           (full ? ofm_pkg::FULL_SCR_ROW : ofm_pkg::LINE_SCR_ROW) : row;
    ro   = 13'({8'h00, r - 5'h01} * 13'(ofm_pkg::ROW_LEN));
    f.err  = 1'b0;
    f.addr = pb + ro + 13'(c);
    unique case (kind)
      3'(ofm_pkg::KIND_PAGE_CHAR), 3'(ofm_pkg::KIND_SCROLL): begin
        if (kind == 3'(ofm_pkg::KIND_SCROLL) && !scr)
          f.err = 1'b1;
        if (mode == ofm_pkg::MODE_PAR40_LINE) begin
          f.err = f.err || rt;
        end else if (full) begin
          if (rt)
            f.addr = f.addr + ofm_pkg::FULL_BLK;
        end else if (rt) begin
          f.addr = f.addr + ofm_pkg::HALF_BLK;
        end
        if (kind == 3'(ofm_pkg::KIND_PAGE_CHAR)) begin
          f.err = f.err || (row == 5'h00) || (full ?
                  (row > ofm_pkg::FULL_LAST) :
                  (row > ofm_pkg::LINE_SCR_ROW));
        end
        f.err = f.err || (col >= 7'(2 * ofm_pkg::ROW_LEN));
      end
      3'(ofm_pkg::KIND_PAGE_ATTR): begin
        f.addr = f.addr + ofm_pkg::HALF_BLK;
        f.err  = (mode != ofm_pkg::MODE_PAR40_LINE) || rt ||
                 (row == 5'h00) || (row > ofm_pkg::LINE_SCR_ROW);
      end
      3'(ofm_pkg::KIND_HDR_CHAR): begin
        f.addr = hb + 13'({8'h00, row} * 13'(ofm_pkg::ROW_LEN)) + 13'(col);
        f.err  = rt || (row >= ofm_pkg::HDR_ROWS);
      end
      3'(ofm_pkg::KIND_HDR_ATTR): begin
        f.addr = hb + ofm_pkg::HS_ATTR_OFS +
                 13'({8'h00, row} * 13'(ofm_pkg::ROW_LEN)) + 13'(col);
        f.err  = (mode != ofm_pkg::MODE_PAR40_LINE) || rt ||
                 (row >= ofm_pkg::HDR_ROWS);
      end
      3'(ofm_pkg::KIND_ROW_ATTR): begin
        f.addr = hb + ofm_pkg::ROW_ATTR_OFS + 13'(row);
        f.err  = full || (row >= ofm_pkg::ROW_ATTR_NUM);
      end
      default: f.err = 1'b1;
    endcase
    if (mode == 2'b10)
      f.err = 1'b1;
    do_fetch = f;
  endfunction

  // ==========================================================
  // font rom address
  function automatic ofm_font_t do_font(
    input logic [8:0] code,
    input logic       p,
    input logic       smos,
    input logic       ssep,
    input logic [1:0] shape,
    input logic       alt,
    input logic [7:0] national_charset_reg
  );
    logic [7:0] c;
    logic       css;
    logic [4:0] slot;
    logic [3:0] sub;
    logic [1:0] set;
    ofm_font_t  f;
    c    = code[7:0];
    css  = p && code[8];
    slot = nat_slot(c);
    sub  = national_charset_reg[3:0];
    set  = alt ? sub[3:2] : sub[1:0];
    f.addr   = {1'b0, c};
    f.valid  = (c >= ofm_pkg::CODE_G0_LO);
    f.mosaic = 1'b0;
    f.sep    = 1'b0;
    if (p ? shape[0] : smos) begin
      f.mosaic = 1'b1;
      f.sep    = p ? shape[1] : ssep;
      f.valid  = 1'b0;
      f.addr   = 9'h000;
    end else if (css && c >= ofm_pkg::CODE_EXT_E) begin
      f.addr = {4'h0, c[4:0]};
    end else if (css && c >= ofm_pkg::CODE_EXT_A) begin
      f.addr = ofm_pkg::EXT_HI_BASE + 9'(c - ofm_pkg::CODE_EXT_A);
    end else if (c >= ofm_pkg::CODE_G0_LO &&
                 c <= ofm_pkg::CODE_G0_HI) begin
      if (national_charset_reg[ofm_pkg::NATIONAL_CHARSET_REG_MAP_BIT]) begin
        unique case (set)
          2'b01:   f.addr = ofm_pkg::G0_1_BASE +
                            9'(c - ofm_pkg::CODE_G0_LO);
          2'b10:   f.addr = ofm_pkg::G0_2_BASE +
                            9'(c - ofm_pkg::CODE_G0_LO);
          default: f.addr = {1'b0, c};
        endcase
      end else if (slot != 5'h10 && sub != 4'h0 &&
                   sub != 4'hf) begin
        f.addr = ofm_pkg::NAT_BASE +
                 9'({5'h00, sub - 4'h1} * ofm_pkg::NAT_LEN) +
                 9'(slot);
      end
    end
    do_font = f;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    ofm_fetch_t fr;
    ofm_font_t  fo;
    next_s = s;
    fr = do_fetch(fetch_kind, fetch_row, fetch_col, s.mode, s.scr,
                  s.pg, s.hs);
    fo = do_font(char_code, par, serial_mosaic, serial_separated,
                 shape_attr, g0_alt, s.national_charset_reg);
    if (psel && !penable && !pwrite) begin
      next_s.prdata = 32'h0000_0000;
      if (hit && idx == ofm_pkg::IDX_NATIONAL_CHARSET_REG)
        next_s.prdata = {24'h000000, s.national_charset_reg};
      if (hit && idx == ofm_pkg::IDX_DPTR)
        next_s.prdata = {24'h000000, s.hs, s.pg};
      if (hit && idx == ofm_pkg::IDX_DCTL)
        next_s.prdata = {29'h0, s.scr, s.mode};
      if (hit && idx == ofm_pkg::IDX_STAT)
        next_s.prdata = {31'h0, s.err_stk};
    end
    if (psel && penable && pwrite && hit) begin
      if (idx == ofm_pkg::IDX_NATIONAL_CHARSET_REG)
        next_s.national_charset_reg = pwdata[7:0];
      if (idx == ofm_pkg::IDX_DPTR) begin
        next_s.pg = pwdata[3:0];
        next_s.hs = pwdata[7:4];
      end
      if (idx == ofm_pkg::IDX_DCTL) begin
        next_s.mode = pwdata[1:0];
        next_s.scr  = pwdata[ofm_pkg::DCTL_SCR_BIT];
      end
      if (idx == ofm_pkg::IDX_STAT && pwdata[ofm_pkg::STAT_ERR_BIT])
        next_s.err_stk = 1'b0;
    end
    next_s.ram_valid = fetch_req && !fr.err;
    next_s.fetch_err = fetch_req && fr.err;
    if (fetch_req) begin
      next_s.ram_addr = fr.addr;
      if (fr.err)
        next_s.err_stk = 1'b1;
    end
    next_s.rom_valid = font_req && fo.valid;
    if (font_req) begin
      next_s.rom_addr = {s.national_charset_reg[ofm_pkg::NATIONAL_CHARSET_REG_SET_BIT], fo.addr};
      next_s.mosaic   = fo.mosaic;
      next_s.sep      = fo.sep;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s      <= '0;
      s.national_charset_reg <= ofm_pkg::NATIONAL_CHARSET_REG_RST;
      s.pg   <= ofm_pkg::DPTR_RST[3:0];
      s.hs   <= ofm_pkg::DPTR_RST[7:4];
      s.mode <= ofm_pkg::DCTL_RST[1:0];
      s.scr  <= ofm_pkg::DCTL_RST[2];
    end else begin
      s <= next_s;
    end
  end

  assign prdata          = s.prdata;
  assign ram_addr        = s.ram_addr;
  assign ram_valid       = s.ram_valid;
  assign fetch_err       = s.fetch_err;
  assign rom_addr        = s.rom_addr;
  assign rom_valid       = s.rom_valid;
  assign glyph_mosaic    = s.mosaic;
  assign glyph_separated = s.sep;

  // ==========================================================
  // checks
  property p_par_attr;
    @(posedge core_clk) disable iff (!resetn)
    fetch_req && fetch_kind == 3'(ofm_pkg::KIND_PAGE_ATTR) |=>
      !ram_valid || ram_addr[12:9] == $past(s.pg) + 4'h1;
  endproperty
  a_par_attr: assert property (p_par_attr)
    else $error("attribute fetch outside next half block");

  property p_hdr_blk;
    @(posedge core_clk) disable iff (!resetn)
    fetch_req && fetch_kind == 3'(ofm_pkg::KIND_HDR_CHAR) |=>
      fetch_err || ram_addr[12:9] == $past(s.hs);
  endproperty
  a_hdr_blk: assert property (p_hdr_blk)
    else $error("header fetch outside header block");

  property p_row_attr;
    @(posedge core_clk) disable iff (!resetn)
    fetch_req && fetch_kind == 3'(ofm_pkg::KIND_ROW_ATTR) |=>
      fetch_err || ram_addr[8:0] == 9'h100 + 9'($past(fetch_row));
  endproperty
  a_row_attr: assert property (p_row_attr)
    else $error("row attribute offset wrong");

  property p_scroll_off;
    @(posedge core_clk) disable iff (!resetn)
    fetch_req && fetch_kind == 3'(ofm_pkg::KIND_SCROLL) && !s.scr
      |=> fetch_err && !ram_valid;
  endproperty
  a_scroll_off: assert property (p_scroll_off)
    else $error("scroll fetch allowed while scrolling is off");

  property p_full_right;
    @(posedge core_clk) disable iff (!resetn)
    fetch_req && s.mode == ofm_pkg::MODE_SER80_FULL &&
    fetch_kind == 3'(ofm_pkg::KIND_PAGE_CHAR) && fetch_col >= 7'h28
      |=> fetch_err || ram_addr >= {$past(s.pg), 9'h000} + 13'h0400;
  endproperty
  a_full_right: assert property (p_full_right)
    else $error("right half not in second block");

  property p_set1;
    @(posedge core_clk) disable iff (!resetn)
    font_req && s.national_charset_reg[6] && !g0_alt && s.national_charset_reg[1:0] == 2'b01 &&
    !glyph_src_mosaic && char_code[7:5] inside {3'h1, 3'h2, 3'h3}
      |=> rom_addr[8:0] == 9'($past(char_code[7:0])) + 9'h0e0;
  endproperty
  a_set1: assert property (p_set1)
    else $error("triple set one base wrong");

  property p_serial_ext;
    @(posedge core_clk) disable iff (!resetn)
    font_req && !par ##1 rom_valid |->
      rom_addr[8:0] >= 9'h020 && rom_addr[8:0] < 9'h1c0;
  endproperty
  a_serial_ext: assert property (p_serial_ext)
    else $error("extended menu reached in serial mode");

  property p_set_bit;
    @(posedge core_clk) disable iff (!resetn)
    font_req |=> rom_addr[9] == $past(s.national_charset_reg[7]);
  endproperty
  a_set_bit: assert property (p_set_bit)
    else $error("font set bit not applied");

  property p_nat1;
    @(posedge core_clk) disable iff (!resetn)
    font_req && !s.national_charset_reg[6] && s.national_charset_reg[3:0] == 4'h1 &&
    !glyph_src_mosaic && char_code[7:0] == 8'h23 |=> rom_addr[8:0] == 9'h100;
  endproperty
  a_nat1: assert property (p_nat1)
    else $error("subset one first slot wrong");

  c_ext: cover property (@(posedge core_clk) disable iff (!resetn)
    rom_valid && rom_addr[8:0] >= 9'h1c0);
  c_mosaic: cover property (@(posedge core_clk) disable iff (!resetn)
    glyph_mosaic && glyph_separated);
  c_scroll: cover property (@(posedge core_clk) disable iff (!resetn)
    fetch_req && fetch_kind == 3'(ofm_pkg::KIND_SCROLL) && s.scr);
  c_err: cover property (@(posedge core_clk) disable iff (!resetn)
    fetch_err);

endmodule

/* File: tb/ofm_mem_model.sv */
// display ram and font rom behind the mapper's fetch side
// assumes one-cycle valid pulses on core_clk
`timescale 1ns/100ps
module ofm_mem_model (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [12:0] ram_addr,
  input  wire logic        ram_valid,
  input  wire logic [9:0]  rom_addr,
  input  wire logic        rom_valid,
  output logic      [7:0]  ram_data,
  output logic      [9:0]  rom_data,
  output int               ram_hits,
  output int               rom_hits
);
  // ==========================================================
  // answers next cycle; idle data toggles so it never holds
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ram_data <= 8'h00;
      rom_data <= 10'h000;
      ram_hits <= 0;
      rom_hits <= 0;
    end else begin
      ram_data <= ram_valid ? ram_addr[7:0] ^ 8'h5a : ~ram_data;
      rom_data <= rom_valid ? ~rom_addr : ~rom_data;
      ram_hits <= ram_hits + (ram_valid ? 1 : 0);
      rom_hits <= rom_hits + (rom_valid ? 1 : 0);
    end
  end
endmodule

/* File: tb/test_ofm_mapper.sv */
// self-checking bench for the page and font address mapper
// assumes ofm_pkg, ofm_mapper and ofm_mem_model compiled before it
`timescale 1ns/100ps
module test_ofm_mapper;
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic        fetch_req, ram_valid, fetch_err, font_req, rom_valid;
  logic        serial_mosaic, serial_separated, g0_alt, sc, er;
  logic        glyph_mosaic, glyph_separated;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  fetch_kind, k;
  logic [4:0]  fetch_row, r;
  logic [6:0]  fetch_col, c;
  logic [12:0] ram_addr;
  logic [9:0]  rom_addr;
  logic [8:0]  char_code;
  logic [1:0]  shape_attr, md;
  logic [3:0]  pg, hs;
  logic [7:0]  nc;
  int          miscompares, samples_checked, cycles, legal, fonts;
  int          ram_hits, rom_hits;
  localparam logic [7:0] SLOT [13] = '{8'h23, 8'h24, 8'h40, 8'h5b,
    8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h7b, 8'h7c, 8'h7d, 8'h7e};
  localparam logic [15:0][8:0] CODES = {9'h023, 9'h024, 9'h040, 9'h05b,
    9'h060, 9'h07b, 9'h07e, 9'h022, 9'h020, 9'h07f, 9'h0ff, 9'h01f,
    9'h1e0, 9'h1ff, 9'h1a0, 9'h1df};
  localparam logic [7:0][7:0] NCS = {8'h00, 8'h01, 8'h0e, 8'h0f,
    8'h4d, 8'h42, 8'h47, 8'hc8};

  // ==========================================================
  // design, memory model, clock and hang limit
  ofm_mapper i_dut (.core_clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .fetch_req,
    .fetch_kind, .fetch_row, .fetch_col, .ram_addr, .ram_valid,
    .fetch_err, .font_req, .char_code, .serial_mosaic,
    .serial_separated, .shape_attr, .g0_alt, .rom_addr, .rom_valid,
    .glyph_mosaic, .glyph_separated);
  ofm_mem_model i_mem (.core_clk, .resetn, .ram_addr, .ram_valid,
    .rom_addr, .rom_valid, .ram_data(), .rom_data(), .ram_hits,
    .rom_hits);

  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  // ==========================================================
  // checking, bus and request tasks
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task stop_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] ix, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask

  task cfg();
    logic [31:0] q;
    logic        e;
    apb(1, ofm_pkg::IDX_DPTR, {24'h0, hs, pg}, q, e);
    apb(1, ofm_pkg::IDX_DCTL, {29'h0, sc, md}, q, e);
    apb(1, ofm_pkg::IDX_NATIONAL_CHARSET_REG, {24'h0, nc}, q, e);
  endtask

  function automatic logic [13:0] exp_fetch(logic [2:0] kd,
                                             logic [4:0] rw, logic [6:0] cl);
    logic        ln;
    logic [12:0] b;
    logic [6:0]  cc;
    ln = (md != 2'b01);
    cc = (cl >= 40) ? cl - 7'd40 : cl;
    b = {pg, 9'h0};
    if (cl >= 40) b = b + (ln ? 13'h200 : 13'h400);
    if (md == 2'b10 || cl >= 80) return 14'h2000;
    case (kd)
      3'h4: return (!ln || rw >= 12) ? 14'h2000 : 14'({hs, 9'h100} + rw);
      3'h2, 3'h3: return 14'({hs, 9'h0} + rw * 40 + cl + kd[0] * 128);
      3'h5: return !sc ? 14'h2000 : 14'(b + (ln ? 440 : 920) + cc);
      default: return 14'(b + (rw - 1) * 40 + cc + kd[0] * 512);
    endcase
  endfunction

  function automatic logic [12:0] exp_font(logic [8:0] cd, logic sm,
                                            logic ss, logic [1:0] sh);
    logic       ex;
    logic [7:0] lo;
    logic [1:0] st;
    logic [8:0] a;
    lo = cd[7:0];
    ex = (md == 2'b00) && cd[8];
    st = g0_alt ? nc[3:2] : nc[1:0];
    a = {1'b0, lo};
    if (md == 2'b00 ? sh[0] : sm) return {(md == 2'b00 ? sh[1] : ss), 12'h800};
    if (ex && lo >= 8'he0) a = 9'(lo - 8'he0);
    else if (ex && lo >= 8'ha0) a = 9'h1c0 + 9'(lo - 8'ha0);
    else if (lo < 8'h20) return 13'h0;
    else if (nc[6] && lo < 8'h80 && st == 2'b01) a = 9'h100 + 9'(lo - 8'h20);
    else if (nc[6] && lo < 8'h80 && st == 2'b10) a = 9'h160 + 9'(lo - 8'h20);
    else if (!nc[6] && nc[3:0] != 0 && nc[3:0] != 15)
      for (int i = 0; i < 13; i++)
        if (lo == SLOT[i]) a = 9'h100 + 9'((nc[3:0] - 1) * 13 + i);
    return {3'b001, nc[7], a};
  endfunction

  task fetch(input logic [2:0] kd, input logic [4:0] rw, input logic [6:0] cl);
    logic [13:0] x;
    x = exp_fetch(kd, rw, cl);
    fetch_req <= 1;
    fetch_kind <= kd;
    fetch_row <= rw;
    fetch_col <= cl;
    @(posedge core_clk);
    fetch_req <= 0;
    @(negedge core_clk);
    chk("fetch_err", 32'(x[13]), 32'(fetch_err));
    chk("ram_valid", 32'(!x[13]), 32'(ram_valid));
    if (!x[13]) chk("ram_addr", 32'(x[12:0]), 32'(ram_addr));
    legal += x[13] ? 0 : 1;
    @(posedge core_clk);
  endtask

  task font(input logic [8:0] cd, input logic sm, input logic ss,
            input logic [1:0] sh);
    logic [12:0] x;
    x = exp_font(cd, sm, ss, sh);
    font_req <= 1;
    char_code <= cd;
    serial_mosaic <= sm;
    serial_separated <= ss;
    shape_attr <= sh;
    @(posedge core_clk);
    font_req <= 0;
    @(negedge core_clk);
    chk("glyph_mosaic", 32'(x[11]), 32'(glyph_mosaic));
    chk("rom_valid", 32'(x[10]), 32'(rom_valid));
    if (x[11]) chk("glyph_separated", 32'(x[12]), 32'(glyph_separated));
    if (x[11]) chk("mosaic rom_addr", 32'h0, 32'(rom_addr[8:0]));
    if (x[10]) chk("rom_addr", 32'(x[9:0]), 32'(rom_addr));
    fonts += x[10] ? 1 : 0;
    @(posedge core_clk);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, fetch_req, font_req, g0_alt} = '0;
    {serial_mosaic, serial_separated, shape_attr, paddr, pwdata} = '0;
    {fetch_kind, fetch_row, fetch_col, char_code} = '0;
    resetn = 0;
    void'($urandom(32'h2388));
    repeat (12) @(posedge core_clk);
    resetn <= 1;
    @(posedge core_clk);
    apb(0, ofm_pkg::IDX_NATIONAL_CHARSET_REG, 0, rd, er);
    chk("national_charset_reg reset", 32'(ofm_pkg::NATIONAL_CHARSET_REG_RST), {24'h0, rd[7:0]});
    apb(0, ofm_pkg::IDX_DPTR, 0, rd, er);
    chk("pointer reset", 32'(ofm_pkg::DPTR_RST), {24'h0, rd[7:0]});
    apb(1, ofm_pkg::IDX_NATIONAL_CHARSET_REG, 32'hc5, rd, er);
    apb(0, ofm_pkg::IDX_NATIONAL_CHARSET_REG, 0, rd, er);
    chk("national_charset_reg rw", 32'hc5, {24'h0, rd[7:0]});
    apb(0, 8'h10, 0, rd, er);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    md = 2'b01;
    sc = 0;
    pg = 4'hb;
    hs = 4'hf;
    nc = 8'h00;
    cfg();
    fetch(0, 23, 79);
    fetch(5, 0, 40);
    fetch(4, 0, 0);
    sc = 1;
    cfg();
    fetch(5, 0, 79);
    md = 2'b11;
    cfg();
    fetch(5, 0, 79);
    fetch(4, 11, 0);
    fetch(4, 12, 0);
    apb(0, ofm_pkg::IDX_STAT, 0, rd, er);
    chk("sticky err", 32'h1, rd);
    apb(1, ofm_pkg::IDX_STAT, 1, rd, er);
    apb(0, ofm_pkg::IDX_STAT, 0, rd, er);
    chk("sticky clear", 32'h0, rd);
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 8; i++) begin
        md = m ? 2'b11 : 2'b00;
        nc = NCS[i];
        g0_alt <= i[0];
        cfg();
        for (int j = 0; j < 16; j++) font(CODES[j], 0, 0, 2'b00);
      end
    end
    for (int i = 0; i < 40; i++) begin
      md = 2'($urandom);
      sc = 1'($urandom);
      pg = 4'($urandom % 12);
      hs = 4'($urandom);
      nc = 8'($urandom) & 8'hcf;
      g0_alt <= 1'($urandom);
      cfg();
      repeat (8) begin
        k = 3'($urandom % 6);
        if (md != 2'b00 && k[0] && k < 4) k = k - 3'h1;
        r = (k == 2 || k == 3) ? 5'($urandom % 3) : k == 4 ?
            5'($urandom % 13) : 5'(1 + $urandom % (md == 2'b01 ? 23 : 12));
        c = 7'($urandom % ((k < 2 || k == 5) && md != 0 ? 84 : 40));
        fetch(k, r, c);
      end
      if (md == 2'b10) begin
        md = 2'b11;
        cfg();
      end
      repeat (8) font(9'($urandom), $urandom % 4 == 0, 1'($urandom),
                      {1'($urandom), 1'($urandom % 4 == 0)});
    end
    @(negedge core_clk);
    chk("ram reads", 32'(legal), 32'(ram_hits));
    chk("rom reads", 32'(fonts), 32'(rom_hits));
    stop_test();
  end
endmodule
